// [rtl/hrft_framer.sv]
/*
 * Register host-to-device frame transmitter: command and control frame
 * sequences, pending tracking, word hand-off to the link layer.
 * Assumes link layer and shadow write port run on core_clk.
 */
`timescale 1ns/1ps
`include "hrft_params.svh"

module hrft_framer #(
    parameter bit CTRL_ON_ANY_WRITE = 1'b0
) (
    input  wire logic        core_clk,
    input  wire logic        soft_reset_bit,
    input  wire logic        sh_wr_en,
    input  wire logic [4:0]  sh_wr_addr,
    input  wire logic [7:0]  sh_wr_data,
    input  wire logic        link_tx_ready,
    input  wire logic        link_illegal,
    input  wire logic        link_rx_active,
    input  wire logic        link_status_valid,
    input  wire logic        link_status_err,
    output logic             tx_req,
    output logic             tx_valid,
    output logic      [31:0] tx_data,
    output logic             tx_last,
    output logic             tx_done,
    output logic             cmd_pending,
    output logic             ctrl_pending
);

    hrft_pkg::hrft_state_t state_q;

    logic        cmd_pending_q;
    logic        ctrl_pending_q;
    logic        soft_reset_bit_prev_q;
    logic [2:0]  word_idx_q;
    logic [1:0]  fetch_q;
    logic        tx_req_q;
    logic        tx_valid_q;
    logic [31:0] tx_data_q;
    logic        tx_last_q;
    logic        tx_done_q;
    logic [31:0] mem_rd_data;
    logic [15:0] mem_hi;

    logic cmd_write;
    logic ctrl_write;
    logic in_build;
    logic link_abort;
    logic start;
    logic last_accept;
    logic cmd_ok;
    logic ctrl_ok;

    // Word 0 header bytes are forced so software cannot corrupt type or flag
    function automatic logic [31:0] frame_word(input logic [31:0] raw, input logic first, input logic is_cmd);
        frame_word = first ? {raw[31:16], is_cmd, 7'h00, `HRFT_FRAME_TYPE} : raw;
    endfunction : frame_word

    // ****************************************************************
    // Shadow register store
    // ****************************************************************
    hrft_shadow_mem #(
        .DEPTH (5),
        .AW    (3)
    ) u_shadow (
        .core_clk (core_clk),
        .soft_reset_bit     (soft_reset_bit),
        .wr_en    (sh_wr_en),
        .wr_addr  (sh_wr_addr),
        .wr_data  (sh_wr_data),
        .rd_addr  (word_idx_q),
        .rd_data  (mem_rd_data)
    );

    assign mem_hi = mem_rd_data[31:16];

    // ****************************************************************
    // Pending tracking
    // ****************************************************************
    assign cmd_write   = sh_wr_en && (sh_wr_addr == `HRFT_ADDR_COMMAND);
    assign ctrl_write  = sh_wr_en && (sh_wr_addr == `HRFT_ADDR_DEVCTL)
                         && (CTRL_ON_ANY_WRITE || (sh_wr_data[`HRFT_SOFT_RESET_BIT_BIT] != soft_reset_bit_prev_q));
    assign cmd_ok      = (state_q == hrft_pkg::command_frame_status_state)
                         && link_status_valid && !link_status_err;
    assign ctrl_ok     = (state_q == hrft_pkg::control_frame_status_state)
                         && link_status_valid && !link_status_err;

    // New write wins over a clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (soft_reset_bit) begin
            cmd_pending_q <= 1'b0;
        end else if (cmd_write) begin
            cmd_pending_q <= 1'b1;
        end else if (cmd_ok) begin
            cmd_pending_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (soft_reset_bit) begin
            ctrl_pending_q <= 1'b0;
        end else if (ctrl_write) begin
            ctrl_pending_q <= 1'b1;
        end else if (ctrl_ok) begin
            ctrl_pending_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (soft_reset_bit) begin
            soft_reset_bit_prev_q <= 1'b0;
        end else if (sh_wr_en && (sh_wr_addr == `HRFT_ADDR_DEVCTL)) begin
            soft_reset_bit_prev_q <= sh_wr_data[`HRFT_SOFT_RESET_BIT_BIT];
        end
    end

    // ****************************************************************
    // Sequence control
    // ****************************************************************
    assign in_build    = (state_q == hrft_pkg::command_frame_build_state)
                         || (state_q == hrft_pkg::control_frame_build_state);
    assign link_abort  = in_build && (link_illegal || link_rx_active);
    assign start       = (state_q == hrft_pkg::transport_idle_state) && !link_rx_active
                         && (cmd_pending_q || ctrl_pending_q);
    assign last_accept = tx_valid_q && link_tx_ready && (word_idx_q == `HRFT_LAST_WORD);

    always_ff @(posedge core_clk) begin
        if (soft_reset_bit) begin
            state_q <= hrft_pkg::transport_idle_state;
        end else begin
            case (state_q)
                hrft_pkg::transport_idle_state: begin
                    // Receive traffic has priority; idle waits it out
                    if (!link_rx_active && cmd_pending_q) begin
                        state_q <= hrft_pkg::command_frame_build_state;
                    end else if (!link_rx_active && ctrl_pending_q) begin
                        state_q <= hrft_pkg::control_frame_build_state;
                    end
                end
                hrft_pkg::command_frame_build_state: begin
                    if (link_abort) begin
                        state_q <= hrft_pkg::transport_idle_state;
                    end else if (last_accept) begin
                        state_q <= hrft_pkg::command_frame_status_state;
                    end
                end
                hrft_pkg::control_frame_build_state: begin
                    if (link_abort) begin
                        state_q <= hrft_pkg::transport_idle_state;
                    end else if (last_accept) begin
                        state_q <= hrft_pkg::control_frame_status_state;
                    end
                end
                hrft_pkg::command_frame_status_state,
                hrft_pkg::control_frame_status_state: begin
                    if (link_status_valid) begin
                        state_q <= hrft_pkg::transport_idle_state;
                    end
                end
                default: begin
                    state_q <= hrft_pkg::transport_idle_state;
                end
            endcase
        end
    end

    // ****************************************************************
    // Word hand-off to the link layer
    // ****************************************************************
    // Two-cycle fetch covers the address register and the store read register
    always_ff @(posedge core_clk) begin
        if (soft_reset_bit) begin
            word_idx_q <= 3'h0;
            fetch_q    <= 2'h0;
            tx_req_q   <= 1'b0;
            tx_valid_q <= 1'b0;
            tx_data_q  <= 32'h0000_0000;
            tx_last_q  <= 1'b0;
            tx_done_q  <= 1'b0;
        end else begin
            tx_done_q <= 1'b0;
            if (start) begin
                word_idx_q <= 3'h0;
                fetch_q    <= 2'h1;
                tx_req_q   <= 1'b1;
            end else if (link_abort) begin
                fetch_q    <= 2'h0;
                tx_req_q   <= 1'b0;
                tx_valid_q <= 1'b0;
                tx_last_q  <= 1'b0;
            end else if (in_build) begin
                fetch_q <= {fetch_q[0], 1'b0};
                if (fetch_q[1]) begin
                    tx_data_q  <= frame_word(mem_rd_data, word_idx_q == 3'h0,
                                  state_q == hrft_pkg::command_frame_build_state);
                    tx_valid_q <= 1'b1;
                    tx_last_q  <= (word_idx_q == `HRFT_LAST_WORD);
                end else if (tx_valid_q && link_tx_ready) begin
                    tx_valid_q <= 1'b0;
                    tx_last_q  <= 1'b0;
                    if (word_idx_q == `HRFT_LAST_WORD) begin
                        tx_done_q <= 1'b1;
                        tx_req_q  <= 1'b0;
                    end else begin
                        word_idx_q <= word_idx_q + 3'h1;
                        fetch_q    <= 2'h1;
                    end
                end
            end
        end
    end

    assign tx_req       = tx_req_q;
    assign tx_valid     = tx_valid_q;
    assign tx_data      = tx_data_q;
    assign tx_last      = tx_last_q;
    assign tx_done      = tx_done_q;
    assign cmd_pending  = cmd_pending_q;
    assign ctrl_pending = ctrl_pending_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (soft_reset_bit);
    a_cmd_flag_set: assert property (
        tx_valid_q && (word_idx_q == 3'h0) && (state_q == hrft_pkg::command_frame_build_state)
        |-> tx_data_q[`HRFT_CMD_FLAG_BIT] && (tx_data_q[7:0] == `HRFT_FRAME_TYPE))
        else $error("command frame without flag bit");

    a_ctrl_flag_clear: assert property (
        tx_valid_q && (word_idx_q == 3'h0) && (state_q == hrft_pkg::control_frame_build_state)
        |-> !tx_data_q[`HRFT_CMD_FLAG_BIT] && tx_req_q)
        else $error("control frame with flag bit set");

    a_payload_shadow: assert property (
        $rose(tx_valid_q) |-> (tx_data_q[31:16] == $past(mem_hi))
        && ((word_idx_q == 3'h0) || (tx_data_q[15:0] == $past(mem_rd_data[15:0]))))
        else $error("payload differs from shadow store");

    a_done_to_status: assert property (
        in_build && !link_abort && last_accept
        |=> tx_done_q && !tx_req_q ##1 !tx_done_q)
        else $error("transmit complete not signalled once");

    a_abort_illegal: assert property (
        in_build && link_illegal |=> (state_q == hrft_pkg::transport_idle_state) && !tx_valid_q)
        else $error("illegal transition did not abort");

    a_abort_receive: assert property (
        in_build && link_rx_active |=> (state_q == hrft_pkg::transport_idle_state) && !tx_req_q)
        else $error("incoming frame did not abort");

    a_status_wait: assert property (
        (state_q == hrft_pkg::command_frame_status_state) && !link_status_valid
        |=> $stable(state_q))
        else $error("status state left without ending status");

    a_good_clears: assert property (
        cmd_ok && !cmd_write |=> !cmd_pending_q && (state_q == hrft_pkg::transport_idle_state))
        else $error("good status did not clear command frame");

    a_error_keeps: assert property (
        ((state_q == hrft_pkg::control_frame_status_state) && link_status_valid && link_status_err)
        |=> ctrl_pending_q && (state_q == hrft_pkg::transport_idle_state))
        else $error("error status dropped pending frame");

    a_cmd_pend_set: assert property (
        cmd_write |=> cmd_pending_q ##1 cmd_pending_q || $past(cmd_ok))
        else $error("command write did not make frame pending");

    a_ctrl_pend_set: assert property (
        ctrl_write |=> ctrl_pending_q)
        else $error("soft reset toggle did not make control frame pending");

    a_idle_start: assert property (
        start |=> in_build && tx_req_q ##2 tx_valid_q || !in_build || $past(link_abort, 2))
        else $error("pending frame not started from idle");

    a_reset_idle: assert property (@(posedge core_clk) disable iff (1'b0)
        soft_reset_bit |=> (state_q == hrft_pkg::transport_idle_state) && !cmd_pending_q && !ctrl_pending_q)
        else $error("reset left a frame pending");
endmodule : hrft_framer

// [rtl/hrft_params.svh]
/*
 * Constants of the register frame transmitter: frame layout, shadow byte
 * offsets and control bit positions.
 * Assumes it is included by its bare name, once per compile unit.
 */
`ifndef HRFT_PARAMS_SVH
`define HRFT_PARAMS_SVH

// ****************************************************************
// Frame layout
// ****************************************************************
`define HRFT_FRAME_TYPE    8'h27
`define HRFT_FRAME_WORDS   3'h5
`define HRFT_LAST_WORD     3'h4
`define HRFT_CMD_FLAG_BIT  15

// ****************************************************************
// Shadow register byte offsets and the soft reset bit position
// ****************************************************************
`define HRFT_ADDR_COMMAND  5'h02
`define HRFT_ADDR_DEVCTL   5'h0F
`define HRFT_SOFT_RESET_BIT_BIT      2

`endif

// [rtl/hrft_pkg.sv]
/*
 * Types of the register frame transmitter.
 * Assumes nothing of its surroundings; used by hrft_framer.
 */
package hrft_pkg;

    typedef enum logic [4:0] {
        transport_idle_state       = 5'h01,
        command_frame_build_state  = 5'h02,
        command_frame_status_state = 5'h04,
        control_frame_build_state  = 5'h08,
        control_frame_status_state = 5'h10
    } hrft_state_t;

endpackage : hrft_pkg

// [rtl/hrft_shadow_mem.sv]
/*
 * Shadow register store: byte writes from software side, word reads
 * with registered data for frame building.
 * Assumes writer and reader share core_clk; reset is synchronous.
 */
`timescale 1ns/1ps

module hrft_shadow_mem #(
    parameter int DEPTH  = 5,
    parameter int AW     = 3
) (
    input  wire logic            core_clk,
    input  wire logic            soft_reset_bit,
    input  wire logic            wr_en,
    input  wire logic [AW+1:0]   wr_addr,
    input  wire logic [7:0]      wr_data,
    input  wire logic [AW-1:0]   rd_addr,
    output logic      [31:0]     rd_data
);

    logic [31:0] mem_q [DEPTH];
    logic [31:0] rd_data_q;

    // ****************************************************************
    // Byte-wide writes, all registers cleared by reset
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (soft_reset_bit) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= 32'h0000_0000;
            end
        end else if (wr_en && (int'(wr_addr[AW+1:2]) < DEPTH)) begin
            mem_q[wr_addr[AW+1:2]][wr_addr[1:0]*8 +: 8] <= wr_data;
        end
    end

    // Out-of-range reads return zero rather than an undefined word
    always_ff @(posedge core_clk) begin
        if (soft_reset_bit) begin
            rd_data_q <= 32'h0000_0000;
        end else if (int'(rd_addr) < DEPTH) begin
            rd_data_q <= mem_q[rd_addr];
        end else begin
            rd_data_q <= 32'h0000_0000;
        end
    end

    assign rd_data = rd_data_q;

endmodule : hrft_shadow_mem

// [test/hrft_link_model.sv]
/*
 * Link layer stand-in for the register frame transmitter: accepts words,
 * records them, returns an ending status after each completed frame.
 * Assumes it shares core_clk and soft_reset_bit with the framer.
 */
`timescale 1ns/1ps

module hrft_link_model (
    input  wire logic        core_clk,
    input  wire logic        soft_reset_bit,
    input  wire logic        tx_req,
    input  wire logic        tx_valid,
    input  wire logic [31:0] tx_data,
    input  wire logic        tx_last,
    input  wire logic        tx_done,
    input  wire logic        slow,
    input  wire logic        err_mode,
    output logic             link_tx_ready,
    output logic             link_status_valid,
    output logic             link_status_err
);
    logic [31:0] words [0:7];
    logic        lasts [0:7];
    int          nwords;
    logic        req_q;
    logic        busy_q;
    logic [1:0]  gap_q;

    // ****************************************************************
    // Word capture
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        req_q <= tx_req;
        link_tx_ready <= soft_reset_bit ? 1'b0 : (slow ? ~link_tx_ready : 1'b1);
        if (soft_reset_bit || (tx_req && !req_q)) begin
            nwords <= 0;
        end else if (tx_valid && link_tx_ready && nwords < 8) begin
            words[nwords] <= tx_data;
            lasts[nwords] <= tx_last;
            nwords <= nwords + 1;
        end
    end

    // ****************************************************************
    // Ending status
    // ****************************************************************
    // Error line flips when unqualified so a stale value never helps
    always_ff @(posedge core_clk) begin
        link_status_valid <= 1'b0;
        link_status_err <= ~link_status_err;
        if (soft_reset_bit) begin
            busy_q <= 1'b0;
            gap_q <= 2'h0;
            link_status_err <= 1'b0;
        end else if (tx_done) begin
            busy_q <= 1'b1;
            gap_q <= 2'h2;
        end else if (busy_q && gap_q == 2'h0) begin
            busy_q <= 1'b0;
            link_status_valid <= 1'b1;
            link_status_err <= err_mode;
        end else begin
            gap_q <= gap_q - 2'h1;
        end
    end
endmodule : hrft_link_model

// [test/host_register_fis_transmit_bench.sv]
/*
 * Self-checking bench of the register frame transmitter.
 * Assumes the link stand-in hrft_link_model and the design constants header.
 */
`timescale 1ns/1ps
`include "hrft_params.svh"

module host_register_fis_transmit_bench;
    logic        core_clk, soft_reset_bit, sh_wr_en, link_illegal, link_rx_active;
    logic [4:0]  sh_wr_addr;
    logic [7:0]  sh_wr_data;
    logic        link_tx_ready, link_status_valid, link_status_err, slow, err_mode;
    logic        tx_req, tx_valid, tx_last, tx_done, cmd_pending, ctrl_pending;
    logic [31:0] tx_data;
    logic [7:0]  sh [0:19];
    int          errors, tests_run;

    hrft_framer dut (.core_clk(core_clk), .soft_reset_bit(soft_reset_bit), .sh_wr_en(sh_wr_en), .sh_wr_addr(sh_wr_addr),
        .sh_wr_data(sh_wr_data), .link_tx_ready(link_tx_ready), .link_illegal(link_illegal),
        .link_rx_active(link_rx_active), .link_status_valid(link_status_valid),
        .link_status_err(link_status_err), .tx_req(tx_req), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_last(tx_last), .tx_done(tx_done), .cmd_pending(cmd_pending), .ctrl_pending(ctrl_pending));
    hrft_link_model link (.core_clk(core_clk), .soft_reset_bit(soft_reset_bit), .tx_req(tx_req), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_done(tx_done), .slow(slow), .err_mode(err_mode),
        .link_tx_ready(link_tx_ready), .link_status_valid(link_status_valid),
        .link_status_err(link_status_err));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic timed_out(input string what);
        errors++;
        $display("[ERR] %s expected 1 seen timeout", what);
        final_report();
    endtask : timed_out

    task automatic sh_write(input logic [4:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sh_wr_en <= 1'b1;
        sh_wr_addr <= a;
        sh_wr_data <= d;
        sh[a] = d;
        @(posedge core_clk);
        sh_wr_en <= 1'b0;
    endtask : sh_write

    function automatic logic [31:0] exp_word(input int i, input logic flag);
        if (i == 0) return {sh[3], sh[2], flag, 7'h00, `HRFT_FRAME_TYPE};
        return {sh[4*i+3], sh[4*i+2], sh[4*i+1], sh[4*i]};
    endfunction : exp_word

    task automatic wait_req;
        int n;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (tx_req !== 1'b1 && n < 50);
        if (tx_req !== 1'b1) timed_out("tx_req");
    endtask : wait_req

    // Waits out one whole frame and judges it, then waits out its status and judges pending
    task automatic run_frame(input logic flag, input logic err);
        int n;
        @(posedge core_clk);
        err_mode <= err;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (tx_done !== 1'b1 && n < 300);
        if (tx_done !== 1'b1) timed_out("tx_done");
        check("word count", 32'(link.nwords), 32'h5);
        for (int i = 0; i < 5; i++) begin
            check("frame word", link.words[i], exp_word(i, flag));
            check("last flag", {31'h0, link.lasts[i]}, {31'h0, i == 4});
        end
        check("tx_req after done", {31'h0, tx_req}, 32'h0);
        n = 0;
        while (link_status_valid !== 1'b1 && n < 20) begin
            @(negedge core_clk);
            n++;
        end
        if (link_status_valid !== 1'b1) timed_out("status");
        @(negedge core_clk);
        check("pending after status", {31'h0, flag ? cmd_pending : ctrl_pending}, {31'h0, err});
    endtask : run_frame

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_cmd;
        for (int a = 4; a < 20; a++) sh_write(5'(a), 8'(a * 37 + 5));
        sh_write(5'h00, 8'hFF);
        sh_write(5'h03, 8'hA5);
        sh_write(`HRFT_ADDR_COMMAND, 8'hEC);
        @(negedge core_clk);
        check("cmd_pending set", {31'h0, cmd_pending}, 32'h1);
        run_frame(1'b1, 1'b0);
        $display("test command frame done");
    endtask : t_cmd

    task automatic t_ctrl;
        slow <= 1'b1;
        sh_write(`HRFT_ADDR_DEVCTL, 8'h04);
        @(negedge core_clk);
        check("ctrl_pending set", {31'h0, ctrl_pending}, 32'h1);
        run_frame(1'b0, 1'b0);
        sh_write(`HRFT_ADDR_DEVCTL, 8'h04);
        repeat (3) @(negedge core_clk);
        check("ctrl_pending no toggle", {30'h0, ctrl_pending, tx_req}, 32'h0);
        sh_write(`HRFT_ADDR_DEVCTL, 8'h00);
        run_frame(1'b0, 1'b0);
        slow <= 1'b0;
        $display("test control frame done");
    endtask : t_ctrl

    task automatic t_err;
        sh_write(`HRFT_ADDR_COMMAND, 8'h35);
        run_frame(1'b1, 1'b1);
        run_frame(1'b1, 1'b0);
        sh_write(`HRFT_ADDR_DEVCTL, 8'h04);
        run_frame(1'b0, 1'b1);
        run_frame(1'b0, 1'b0);
        $display("test error resend done");
    endtask : t_err

    task automatic t_abort;
        sh_write(`HRFT_ADDR_COMMAND, 8'h91);
        wait_req();
        @(posedge core_clk);
        link_illegal <= 1'b1;
        @(posedge core_clk);
        link_illegal <= 1'b0;
        @(negedge core_clk);
        check("abort on illegal", {30'h0, tx_req, cmd_pending}, 32'h1);
        wait_req();
        @(posedge core_clk);
        link_rx_active <= 1'b1;
        repeat (4) @(negedge core_clk);
        check("abort on receive", {30'h0, tx_req, tx_done}, 32'h0);
        @(posedge core_clk);
        link_rx_active <= 1'b0;
        run_frame(1'b1, 1'b0);
        $display("test abort done");
    endtask : t_abort

    task automatic t_both;
        @(posedge core_clk);
        link_rx_active <= 1'b1;
        sh_write(`HRFT_ADDR_DEVCTL, 8'h00);
        sh_write(`HRFT_ADDR_COMMAND, 8'h5A);
        @(posedge core_clk);
        link_rx_active <= 1'b0;
        run_frame(1'b1, 1'b0);
        run_frame(1'b0, 1'b0);
        $display("test priority done");
    endtask : t_both

    initial begin
        errors = 0;
        tests_run = 0;
        soft_reset_bit = 1'b1;
        sh_wr_en = 1'b0;
        sh_wr_addr = 5'h00;
        sh_wr_data = 8'h00;
        link_illegal = 1'b0;
        link_rx_active = 1'b0;
        slow = 1'b0;
        err_mode = 1'b0;
        for (int a = 0; a < 20; a++) sh[a] = 8'h00;
        repeat (16) @(posedge core_clk);
        soft_reset_bit <= 1'b0;
        @(negedge core_clk);
        check("reset outputs", {26'h0, tx_req, tx_valid, tx_last, tx_done, cmd_pending, ctrl_pending}, 32'h0);
        $display("test reset done");
        t_cmd();
        t_ctrl();
        t_err();
        t_abort();
        t_both();
        final_report();
    end
endmodule : host_register_fis_transmit_bench
